// *** design/bscp_consts.svh ***
// Constants for the boot select and code protection block.
// Assumes inclusion by bare name from the design files.
`ifndef BSCP_CONSTS_SVH
`define BSCP_CONSTS_SVH

// Security option bits, erased state is all ones
`define BSCP_OPT_ERASED 8'hff
`define BSCP_OPT_LOCK 0
`define BSCP_OPT_CTAB_INH 1
`define BSCP_OPT_REBOOT_AB 4
`define BSCP_OPT_REBOOT_C 5
`define BSCP_OPT_CLK_FAST 7

// isp_control_reg values and fields
`define BSCP_ISP_RESET 8'h00
`define BSCP_ISP_LDR_MODE 8'h03
`define BSCP_ISP_APP_MODE 8'h01
`define BSCP_ISP_SWRST 7

// flash_bank_select_reg fields
`define BSCP_BANK_RESET 8'h00
`define BSCP_BANK_SEL 0
`define BSCP_BANK_LDR_TGT 1

`endif

// *** design/bscp_pkg.sv ***
// Types shared by the boot select and code protection files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package bscp_pkg;
  typedef enum logic [1:0] {
    BSCP_TGT_APP0 = 2'b00,
    BSCP_TGT_APP1 = 2'b01,
    BSCP_TGT_LDR = 2'b10
  } bscp_tgt_t;

  typedef enum logic [0:0] {
    BSCP_SRC_APP = 1'b0,
    BSCP_SRC_LDR = 1'b1
  } bscp_src_t;
endpackage : bscp_pkg
`default_nettype wire

// *** design/bscp_opt_store.sv ***
// Security option bit storage, program one-to-zero, erase to ones.
// Assumes the caller has already qualified write and erase strobes.
`include "bscp_consts.svh"
`default_nettype none
module bscp_opt_store (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [7:0] wdata,
  input wire logic erase,
  output logic [7:0] opt_r
);
  logic [7:0] opt_nxt;

  // Programming can only pull bits low; erase or an arst_n reset brings them back up
  assign opt_nxt = erase ? `BSCP_OPT_ERASED :
                   wr_en ? (opt_r & wdata) : opt_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      opt_r <= `BSCP_OPT_ERASED;
    end else begin
      opt_r <= opt_nxt;
    end
  end
endmodule : bscp_opt_store
`default_nettype wire

// *** design/bscp_top.sv ***
// Boot source selection, in-system programming switch and code
// protection. Assumes core strobes and strap pins are synchronous.
//
// What this block does
// - Option bits once programmed low stay low until a full erase or arst_n reset.
// - The option register is reachable only in programmer mode.
// - A low lock bit refuses programmer flash and option access.
// - With inhibit low, external table reads never see internal code.
// - Table reads from internal code may always read both memories.
// - With inhibit high, table reads are not restricted.
// - Reboot bit 4 low with straps a and b low boots the loader.
// - Reboot bit 5 low with strap c low boots the loader.
// - Idle with isp value 03h switches to loader and resets the core.
// - Strap reboot also selects the loader as program source.
// - The software reboot bit returns to application and resets.
// - A loader may update application bank 0 or 1 by bank select.
// - Idle with isp value 01h allows updates without any reset.
// - Without a reboot strap the core starts in application flash.
`include "bscp_consts.svh"
`default_nettype none
module bscp_top (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic rst_pin,
  input wire logic strap_pin_a,
  input wire logic strap_pin_b,
  input wire logic strap_pin_c,
  input wire logic prog_mode,
  input wire logic prog_opt_wr,
  input wire logic prog_opt_rd,
  input wire logic [7:0] prog_wdata,
  input wire logic prog_flash_req,
  input wire logic prog_erase_all,
  input wire logic cpu_idle,
  input wire logic cpu_isp_wr,
  input wire logic [7:0] cpu_isp_wdata,
  input wire logic cpu_bank_wr,
  input wire logic [7:0] cpu_bank_wdata,
  input wire logic ctab_req,
  input wire logic ctab_in_internal,
  input wire logic ctab_tgt_internal,
  output logic fetch_from_loader_r,
  output logic cpu_reset_r,
  output logic update_en_r,
  output logic [1:0] update_target_r,
  output logic [7:0] isp_rdata_r,
  output logic [7:0] bank_rdata_r,
  output logic ctab_done_r,
  output logic ctab_internal_ok_r,
  output logic clk_fast_r,
  output logic prog_ack_r,
  output logic prog_refused_r,
  output logic [7:0] prog_rdata_r,
  output logic prog_flash_grant_r
);
  logic [7:0] opt_q;
  logic [7:0] isp_r;
  logic [7:0] isp_nxt;
  logic [7:0] bank_r;
  logic app_mode_r;
  logic app_mode_nxt;
  logic fetch_nxt;
  logic reboot_pulse;

  // Programmer side qualification
  wire prog_any = prog_opt_wr | prog_opt_rd | prog_flash_req;
  wire locked = ~opt_q[`BSCP_OPT_LOCK];
  wire prog_ok = prog_mode & ~locked;
  wire store_wr = prog_ok & prog_opt_wr;
  // Erase-all stays open when locked, else a locked part is a brick
  wire store_erase = prog_mode & prog_erase_all;

  bscp_opt_store u_store (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(store_wr),
    .wdata(prog_wdata),
    .erase(store_erase),
    .opt_r(opt_q)
  );

  // Strap reboot decode
  wire boot_ab = ~opt_q[`BSCP_OPT_REBOOT_AB] & ~strap_pin_a &
                 ~strap_pin_b;
  wire boot_c = ~opt_q[`BSCP_OPT_REBOOT_C] & ~strap_pin_c;
  wire boot_ldr = boot_ab | boot_c;

  // Core side events, a reboot write beats idle in the same cycle
  wire sw_reboot = cpu_isp_wr & cpu_isp_wdata[`BSCP_ISP_SWRST];
  wire idle_ldr = cpu_idle & ~cpu_isp_wr &
                  (isp_r == `BSCP_ISP_LDR_MODE);
  wire idle_app = cpu_idle & ~cpu_isp_wr &
                  (isp_r == `BSCP_ISP_APP_MODE);

  // Straps are followed while the pin holds reset, so the value kept
  // is the one seen on the last reset cycle
  assign fetch_nxt = rst_pin ? boot_ldr :
                     sw_reboot ? 1'b0 :
                     idle_ldr ? 1'b1 : fetch_from_loader_r;
  assign reboot_pulse = ~rst_pin & (sw_reboot | idle_ldr);
  assign isp_nxt = rst_pin ? `BSCP_ISP_RESET :
                   sw_reboot ? `BSCP_ISP_RESET :
                   cpu_isp_wr ? cpu_isp_wdata :
                   idle_ldr ? `BSCP_ISP_RESET : isp_r;
  // Idle with isp value 01h sets the update flag; an isp write in the same cycle blocks idle and clears it
  assign app_mode_nxt = rst_pin ? 1'b0 :
                        idle_app ? 1'b1 :
                        (cpu_isp_wr | reboot_pulse) ? 1'b0 : app_mode_r;

  // Update target: loader code writes only application banks
  wire [1:0] tgt_nxt = fetch_nxt ?
    {1'b0, bank_r[`BSCP_BANK_SEL]} :
    (bank_r[`BSCP_BANK_LDR_TGT] ? bscp_pkg::BSCP_TGT_LDR :
     {1'b0, bank_r[`BSCP_BANK_SEL]});

  // Inhibit only blocks external code reading internal memory
  wire ctab_ok = ~ctab_tgt_internal | ctab_in_internal |
                 opt_q[`BSCP_OPT_CTAB_INH];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fetch_from_loader_r <= bscp_pkg::BSCP_SRC_APP;
      cpu_reset_r <= 1'b1;
      isp_r <= `BSCP_ISP_RESET;
      app_mode_r <= 1'b0;
      update_en_r <= 1'b0;
      update_target_r <= bscp_pkg::BSCP_TGT_APP0;
    end else begin
      fetch_from_loader_r <= fetch_nxt;
      cpu_reset_r <= rst_pin | reboot_pulse;
      isp_r <= isp_nxt;
      app_mode_r <= app_mode_nxt;
      update_en_r <= fetch_nxt & ~rst_pin | app_mode_nxt;
      update_target_r <= tgt_nxt;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_r <= `BSCP_BANK_RESET;
    end else if (rst_pin) begin
      bank_r <= `BSCP_BANK_RESET;
    end else if (cpu_bank_wr) begin
      bank_r <= cpu_bank_wdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      isp_rdata_r <= `BSCP_ISP_RESET;
      bank_rdata_r <= `BSCP_BANK_RESET;
      clk_fast_r <= 1'b1;
      ctab_done_r <= 1'b0;
      ctab_internal_ok_r <= 1'b0;
    end else begin
      isp_rdata_r <= isp_nxt;
      bank_rdata_r <= bank_r;
      // Frequency bit is the programmer's to set right
      clk_fast_r <= opt_q[`BSCP_OPT_CLK_FAST];
      ctab_done_r <= ctab_req;
      ctab_internal_ok_r <= ctab_req & ctab_ok;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prog_ack_r <= 1'b0;
      prog_refused_r <= 1'b0;
      prog_rdata_r <= 8'h00;
      prog_flash_grant_r <= 1'b0;
    end else begin
      prog_ack_r <= prog_ok & prog_any | store_erase;
      prog_refused_r <= prog_mode & locked & prog_any;
      prog_flash_grant_r <= prog_ok & prog_flash_req;
      if (prog_ok & prog_opt_rd) begin
        prog_rdata_r <= opt_q;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_one_way;
    !store_erase |=> ((opt_q & ~$past(opt_q)) == 8'h00);
  endproperty
  a_one_way: assert property (p_one_way)
    else $error("option bit rose without erase");

  property p_normal_blocked;
    !prog_mode && prog_any |=> !prog_ack_r && !prog_flash_grant_r;
  endproperty
  a_normal_blocked: assert property (p_normal_blocked)
    else $error("option access outside programmer mode");

  property p_lock_refuse;
    prog_mode && prog_any && !opt_q[0] |=>
      prog_refused_r && !prog_flash_grant_r && !prog_ack_r;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse)
    else $error("locked part answered programmer");

  property p_ctab_inhibit;
    ctab_req && !ctab_in_internal && ctab_tgt_internal && !opt_q[1]
      |=> ctab_done_r && !ctab_internal_ok_r;
  endproperty
  a_ctab_inhibit: assert property (p_ctab_inhibit)
    else $error("external table read reached internal code");

  property p_ctab_internal;
    ctab_req && ctab_in_internal |=> ctab_internal_ok_r;
  endproperty
  a_ctab_internal: assert property (p_ctab_internal)
    else $error("internal table read was refused");

  property p_ctab_free;
    ctab_req && opt_q[1] |=> ctab_done_r && ctab_internal_ok_r;
  endproperty
  a_ctab_free: assert property (p_ctab_free)
    else $error("table read refused with inhibit off");

  property p_boot_ab;
    $fell(rst_pin) && $past(!opt_q[4] && !strap_pin_a && !strap_pin_b)
      |-> fetch_from_loader_r;
  endproperty
  a_boot_ab: assert property (p_boot_ab)
    else $error("strap a b reboot did not select loader");

  property p_boot_c;
    $fell(rst_pin) && $past(!opt_q[5] && !strap_pin_c)
      |-> fetch_from_loader_r;
  endproperty
  a_boot_c: assert property (p_boot_c)
    else $error("strap c reboot did not select loader");

  property p_boot_app;
    $fell(rst_pin) && $past(!boot_ldr) |-> !fetch_from_loader_r;
  endproperty
  a_boot_app: assert property (p_boot_app)
    else $error("default boot not from application");

  property p_isp_ldr;
    !rst_pin && idle_ldr |=> fetch_from_loader_r && cpu_reset_r
      ##1 !cpu_reset_r;
  endproperty
  a_isp_ldr: assert property (p_isp_ldr)
    else $error("idle with 03h did not reboot to loader");

  property p_sw_reboot;
    !rst_pin && sw_reboot |=> !fetch_from_loader_r && cpu_reset_r;
  endproperty
  a_sw_reboot: assert property (p_sw_reboot)
    else $error("software reboot did not return to application");

  property p_app_mode;
    !rst_pin && idle_app |=> update_en_r && !cpu_reset_r;
  endproperty
  a_app_mode: assert property (p_app_mode)
    else $error("01h idle mode reset or did not enable update");

  property p_hold;
    !rst_pin && !cpu_isp_wr && !cpu_idle |=> $stable(fetch_from_loader_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("boot source moved outside reset");

  c_boot_loader: cover property ($fell(rst_pin) && fetch_from_loader_r);
  c_isp_ldr: cover property (!rst_pin && idle_ldr);
  c_sw_reboot: cover property (!rst_pin && sw_reboot);
  c_lock: cover property (prog_refused_r);
endmodule : bscp_top
`default_nettype wire

// *** test/bscp_prog_model.sv ***
// Device programmer and boot strap pins at the far side of the block.
// Assumes the bench calls its tasks; idle strap pins sit pulled high.
`default_nettype none
module bscp_prog_model (
  input wire logic clock,
  output logic prog_mode,
  output logic prog_opt_wr,
  output logic prog_opt_rd,
  output logic [7:0] prog_wdata,
  output logic prog_flash_req,
  output logic prog_erase_all,
  output logic strap_pin_a,
  output logic strap_pin_b,
  output logic strap_pin_c
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {prog_mode, prog_opt_wr, prog_opt_rd} = 3'h4;
    {prog_flash_req, prog_erase_all} = 2'h0;
    prog_wdata = 8'h00;
    {strap_pin_a, strap_pin_b, strap_pin_c} = 3'h7;
  end
  // Kinds: 0 option write, 1 option read, 2 flash access, 3 erase all
  task automatic op(input int k, input logic [7:0] d, input logic m);
    @(posedge clock);
    prog_mode <= m;
    prog_wdata <= d | 8'h80;
    prog_opt_wr <= (k == 0);
    prog_opt_rd <= (k == 1);
    prog_flash_req <= (k == 2);
    prog_erase_all <= (k == 3);
    @(posedge clock);
    {prog_opt_wr, prog_opt_rd, prog_flash_req, prog_erase_all} <= 4'h0;
    prog_mode <= 1'b1;
    // Released data bus must not look like the last value
    prog_wdata <= ~(d | 8'h80);
  endtask : op
  task automatic straps(input logic [2:0] s);
    @(posedge clock);
    {strap_pin_c, strap_pin_b, strap_pin_a} <= s;
  endtask : straps
endmodule : bscp_prog_model
`default_nettype wire

// *** test/bscp_top_tb.sv ***
// Self-checking bench for the boot select and code protection top.
// Assumes the programmer model drives straps and programmer strobes.
`default_nettype none
module bscp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, arst_n, rst_pin, strap_pin_a, strap_pin_b, strap_pin_c;
  logic prog_mode, prog_opt_wr, prog_opt_rd, prog_flash_req;
  logic prog_erase_all, cpu_idle, cpu_isp_wr, cpu_bank_wr, ctab_req;
  logic ctab_in_internal, ctab_tgt_internal, fetch_from_loader_r;
  logic cpu_reset_r, update_en_r, ctab_done_r, ctab_internal_ok_r;
  logic clk_fast_r, prog_ack_r, prog_refused_r, prog_flash_grant_r;
  logic [1:0] update_target_r;
  logic [7:0] prog_wdata, cpu_isp_wdata, cpu_bank_wdata, isp_rdata_r;
  logic [7:0] bank_rdata_r, prog_rdata_r;
  int bad_count, n_tests, seed;

  bscp_top u_bscp_top (.clock, .arst_n, .rst_pin, .strap_pin_a,
    .strap_pin_b, .strap_pin_c, .prog_mode, .prog_opt_wr, .prog_opt_rd,
    .prog_wdata, .prog_flash_req, .prog_erase_all, .cpu_idle,
    .cpu_isp_wr, .cpu_isp_wdata, .cpu_bank_wr, .cpu_bank_wdata,
    .ctab_req, .ctab_in_internal, .ctab_tgt_internal,
    .fetch_from_loader_r, .cpu_reset_r, .update_en_r, .update_target_r,
    .isp_rdata_r, .bank_rdata_r, .ctab_done_r, .ctab_internal_ok_r,
    .clk_fast_r, .prog_ack_r, .prog_refused_r, .prog_rdata_r,
    .prog_flash_grant_r);
  bscp_prog_model u_bscp_prog_model (.clock, .prog_mode, .prog_opt_wr,
    .prog_opt_rd, .prog_wdata, .prog_flash_req, .prog_erase_all,
    .strap_pin_a, .strap_pin_b, .strap_pin_c);

  always #4 clock = ~clock;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  function automatic logic ok_exp(input logic in_int, input logic inh);
    return in_int | inh;
  endfunction : ok_exp
  task automatic pg(input int k, input logic [7:0] d, input logic m);
    u_bscp_prog_model.op(k, d, m);
    @(negedge clock);
  endtask : pg
  // Kinds: 0 isp write, 1 bank write, 2 idle
  task automatic cpu(input int k, input logic [7:0] d);
    @(posedge clock);
    cpu_isp_wr <= (k == 0);
    cpu_bank_wr <= (k == 1);
    cpu_idle <= (k == 2);
    cpu_isp_wdata <= d;
    cpu_bank_wdata <= d;
    @(posedge clock);
    {cpu_isp_wr, cpu_bank_wr, cpu_idle} <= 3'h0;
    @(negedge clock);
  endtask : cpu
  // Straps as {c, b, a}; released again right after reset falls
  task automatic boot(input logic [2:0] s);
    u_bscp_prog_model.straps(s);
    rst_pin <= 1'b1;
    repeat (3) @(negedge clock);
    chk(cpu_reset_r, 1'b1);
    @(posedge clock);
    rst_pin <= 1'b0;
    u_bscp_prog_model.straps(3'h7);
    repeat (2) @(negedge clock);
  endtask : boot
  task automatic ctab_read(input logic inh);
    logic [31:0] r;
    r = $random(seed);
    @(posedge clock);
    ctab_req <= 1'b1;
    ctab_in_internal <= r[0];
    ctab_tgt_internal <= r[1];
    @(posedge clock);
    ctab_req <= 1'b0;
    @(negedge clock);
    chk(ctab_done_r, 1'b1);
    if (r[1]) chk(ctab_internal_ok_r, ok_exp(r[0], inh));
  endtask : ctab_read

  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    seed = 58444;
    {clock, arst_n, rst_pin, cpu_idle, cpu_isp_wr, cpu_bank_wr} = '0;
    {ctab_req, ctab_in_internal, ctab_tgt_internal} = '0;
    {cpu_isp_wdata, cpu_bank_wdata} = '0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    @(negedge clock);
    chk(fetch_from_loader_r, 1'b0);
    chk(clk_fast_r, 1'b1);
    boot(3'h4);
    chk(fetch_from_loader_r, 1'b0);
    pg(0, 8'h00, 1'b0);
    chk(prog_ack_r, 1'b0);
    pg(0, 8'hcd, 1'b1);
    chk(prog_ack_r, 1'b1);
    pg(0, 8'hff, 1'b1);
    pg(1, 8'h00, 1'b1);
    chk(prog_rdata_r, 8'hcd);
    pg(2, 8'h00, 1'b1);
    chk({prog_refused_r, prog_flash_grant_r}, 8'h01);
    boot(3'h4);
    chk(fetch_from_loader_r, 1'b1);
    cpu(0, 8'h80);
    chk({fetch_from_loader_r, cpu_reset_r}, 8'h01);
    boot(3'h3);
    chk(fetch_from_loader_r, 1'b1);
    cpu(0, 8'h80);
    repeat (16) ctab_read(1'b0);
    cpu(1, 8'h01);
    cpu(0, 8'h03);
    chk(isp_rdata_r, 8'h03);
    chk(bank_rdata_r, 8'h01);
    cpu(2, 8'h00);
    chk({fetch_from_loader_r, cpu_reset_r, update_en_r}, 8'h07);
    chk(update_target_r, 8'h01);
    @(negedge clock);
    chk(cpu_reset_r, 1'b0);
    cpu(0, 8'h80);
    cpu(1, 8'h02);
    cpu(0, 8'h01);
    cpu(2, 8'h00);
    chk({fetch_from_loader_r, cpu_reset_r, update_en_r}, 8'h01);
    chk(update_target_r, 8'h02);
    pg(0, 8'hcc, 1'b1);
    pg(1, 8'h00, 1'b1);
    chk(prog_refused_r, 1'b1);
    pg(2, 8'h00, 1'b1);
    chk({prog_refused_r, prog_flash_grant_r}, 8'h02);
    pg(3, 8'h00, 1'b1);
    chk(prog_ack_r, 1'b1);
    pg(1, 8'h00, 1'b1);
    chk(prog_rdata_r, 8'hff);
    repeat (16) ctab_read(1'b1);
    complete_run();
  end
endmodule : bscp_top_tb
`default_nettype wire
